/* core/bulk_in_delay_timer.sv */
// hold-off timer for short bulk-in packets
module bulk_in_delay_timer
    import fifo_level_pkg::*;
(
    input  wire logic                           clk_in,
    input  wire logic                           rstn_in,
    input  wire logic                           ce_in,
    input  wire logic [fifo_level_pkg::DLY_W-1:0] delay_in,
    input  wire logic                           req_in,
    output logic                                go_out
);
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [DLY_W-1:0] cnt;
        logic             busy;
        logic             go;
    } tmr_state_type;

    tmr_state_type    st_q;
    tmr_state_type    st_d;
    logic [ACC_W-1:0] acc_sum;
    logic             tick;

    // fractional accumulator makes a 60 MHz step from the core clock
    // without a second clock domain; jitter is under one core cycle
    always_comb begin
        st_d    = st_q;
        st_d.go = 1'b0;
        acc_sum = st_q.acc + ACC_W'(CLK_PERIOD_PS);
        tick    = acc_sum >= ACC_W'(DELAY_STEP_PS);
        if (req_in) begin
            st_d.acc  = '0;                                       // [R14]
            st_d.cnt  = delay_in;
            st_d.busy = delay_in != '0;
            st_d.go   = delay_in == '0;
        end else if (st_q.busy) begin
            st_d.acc = tick ? acc_sum - ACC_W'(DELAY_STEP_PS) : acc_sum;
            if (tick) begin
                if (st_q.cnt <= DLY_W'(1)) begin
                    st_d.busy = 1'b0;                             // [R1]
                    st_d.go   = 1'b1;
                    st_d.cnt  = '0;
                end else begin
                    st_d.cnt = st_q.cnt - DLY_W'(1);
                end
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    assign go_out = st_q.go;

endmodule

/* core/fifo_level_counter.sv */
// occupancy and pointer tracking for one packet FIFO
module fifo_level_counter #(
    parameter int LVL_W = 14,
    parameter int PTR_W = 13
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic             ce_in,
    input  wire logic             wr_dword_in,
    input  wire logic             wr_end_in,
    input  wire logic             wr_rewind_in,
    input  wire logic             rd_dword_in,
    input  wire logic             rd_end_in,
    input  wire logic             rd_rewind_in,
    output logic [LVL_W-1:0]      rd_level_out,
    output logic [LVL_W-1:0]      wr_level_out,
    output logic [PTR_W-1:0]      rd_ptr_out,
    output logic [PTR_W-1:0]      wr_ptr_out
);
    typedef struct packed {
        logic [LVL_W-1:0] rd_lvl;
        logic [LVL_W-1:0] wr_lvl;
        logic [LVL_W-1:0] wr_cnt;
        logic [LVL_W-1:0] rd_cnt;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W-1:0] wr_ptr;
    } cnt_state_type;

    cnt_state_type    st_q;
    cnt_state_type    st_d;
    logic             wr_take;
    logic             commit;
    logic             rd_take;
    logic             drained;
    logic [LVL_W-1:0] wr_pkt;
    logic [LVL_W-1:0] rd_pkt;

    // a rewind wins over a data beat or packet end in the same cycle
    always_comb begin
        st_d    = st_q;
        wr_take = wr_dword_in && !wr_rewind_in;
        commit  = wr_end_in && !wr_rewind_in;
        rd_take = rd_dword_in && !rd_rewind_in;
        drained = rd_end_in && !rd_rewind_in;
        wr_pkt  = st_q.wr_cnt + LVL_W'(wr_take);
        rd_pkt  = st_q.rd_cnt + LVL_W'(rd_take);
        // write side
        if (wr_rewind_in) begin
            st_d.wr_lvl = st_q.wr_lvl - st_q.wr_cnt;              // [R9] [R10]
            st_d.wr_ptr = st_q.wr_ptr - PTR_W'(st_q.wr_cnt);
            st_d.wr_cnt = '0;
        end else begin
            st_d.wr_lvl = st_q.wr_lvl + LVL_W'(wr_take);          // [R7]
            st_d.wr_ptr = st_q.wr_ptr + PTR_W'(wr_take);
            st_d.wr_cnt = commit ? '0 : wr_pkt;
        end
        if (drained) begin
            st_d.wr_lvl = st_d.wr_lvl - rd_pkt;                   // [R8]
        end
        // read side
        if (rd_rewind_in) begin
            st_d.rd_lvl = st_q.rd_lvl + st_q.rd_cnt;              // [R5]
            st_d.rd_ptr = st_q.rd_ptr - PTR_W'(st_q.rd_cnt);
            st_d.rd_cnt = '0;
        end else begin
            st_d.rd_lvl = st_q.rd_lvl - LVL_W'(rd_take);          // [R4]
            st_d.rd_ptr = st_q.rd_ptr + PTR_W'(rd_take);
            st_d.rd_cnt = drained ? '0 : rd_pkt;
        end
        if (commit) begin
            st_d.rd_lvl = st_d.rd_lvl + wr_pkt;                   // [R3]
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    assign rd_level_out = st_q.rd_lvl;
    assign wr_level_out = st_q.wr_lvl;
    assign rd_ptr_out   = st_q.rd_ptr;
    assign wr_ptr_out   = st_q.wr_ptr;

endmodule

/* core/fifo_level_pkg.sv */
// constants, register map and types shared by the packet FIFO level tracker
package fifo_level_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses on the AXI4-Lite slave
    // ------------------------------------------------------------------
    localparam int         AXI_AW      = 8;
    localparam logic [7:0] BULK_DLY_OFS = 8'h6C;
    localparam logic [7:0] RX_LVL_OFS   = 8'h70;
    localparam logic [7:0] RX_PTR_OFS   = 8'h74;
    localparam logic [7:0] TX_LVL_OFS   = 8'h78;

    // ------------------------------------------------------------------
    // field widths and positions
    // ------------------------------------------------------------------
    localparam int RX_LVL_W   = 14;
    localparam int RX_PTR_W   = 13;
    localparam int TX_LVL_W   = 12;
    localparam int TX_PTR_W   = 11;
    localparam int DLY_W      = 16;
    localparam int RD_FLD_LSB = 16;
    localparam int WR_FLD_LSB = 0;

    // ------------------------------------------------------------------
    // reset values, responses and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] DLY_RESET     = 16'h0800;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          DELAY_STEP_PS = 16667;
    localparam int          ACC_W         = 15;

    typedef enum logic [2:0] {
        SEL_DLY,
        SEL_RX_LVL,
        SEL_RX_PTR,
        SEL_TX_LVL,
        SEL_NONE
    } reg_sel_type;

endpackage

/* core/packet_fifo_level_tracker.sv */
// packet FIFO level tracker top with AXI4-Lite debug and delay registers
//
// How it works
// R1: short bulk-in packet waits the programmed delay, in steps of 16.667 ns
// R2: delay field is 16-bit read/write in bits 15:0, reset 800h
// R3: read-side level rises by whole packet only after full packet written
// R4: read-side level drops by one per word read out
// R5: receive read rewind adds back the words already read
// R6: transmit read side has no rewind
// R7: write-side level rises by one per word written
// R8: write-side level drops by packet size once packet fully read
// R9: receive write rewind drops the partial packet from write-side level
// R10: errored bulk-out packet rewound out of transmit FIFO; host resends
// R11: receive levels read-only at bits 29:16 and 13:0, reset zero
// R12: transmit levels read-only at bits 27:16 and 11:0, reset zero
// R13: receive pointers read-only at bits 28:16 and 12:0, reset zero
// R14: delay timer counts 60 MHz steps, reloads per request, releases at expiry
//
// Implementation choice: the AXI4-Lite slave port.
module packet_fifo_level_tracker (
    input  wire logic                                CLK_IN,
    input  wire logic                                RSTN_IN,
    input  wire logic                                CE_IN,
    // axi4-lite slave
    input  wire logic [fifo_level_pkg::AXI_AW-1:0]   S_AXI_AWADDR_IN,
    input  wire logic                                S_AXI_AWVALID_IN,
    output logic                                     S_AXI_AWREADY_OUT,
    input  wire logic [31:0]                         S_AXI_WDATA_IN,
    input  wire logic [3:0]                          S_AXI_WSTRB_IN,
    input  wire logic                                S_AXI_WVALID_IN,
    output logic                                     S_AXI_WREADY_OUT,
    output logic [1:0]                               S_AXI_BRESP_OUT,
    output logic                                     S_AXI_BVALID_OUT,
    input  wire logic                                S_AXI_BREADY_IN,
    input  wire logic [fifo_level_pkg::AXI_AW-1:0]   S_AXI_ARADDR_IN,
    input  wire logic                                S_AXI_ARVALID_IN,
    output logic                                     S_AXI_ARREADY_OUT,
    output logic [31:0]                              S_AXI_RDATA_OUT,
    output logic [1:0]                               S_AXI_RRESP_OUT,
    output logic                                     S_AXI_RVALID_OUT,
    input  wire logic                                S_AXI_RREADY_IN,
    // receive FIFO events, mac writes and usb reads
    input  wire logic                                RX_WR_DWORD_IN,
    input  wire logic                                RX_WR_END_IN,
    input  wire logic                                RX_WR_REWIND_IN,
    input  wire logic                                RX_RD_DWORD_IN,
    input  wire logic                                RX_RD_END_IN,
    input  wire logic                                RX_RD_REWIND_IN,
    // transmit FIFO events, usb writes and mac reads
    input  wire logic                                TX_WR_DWORD_IN,
    input  wire logic                                TX_WR_END_IN,
    input  wire logic                                TX_WR_REWIND_IN,
    input  wire logic                                TX_RD_DWORD_IN,
    input  wire logic                                TX_RD_END_IN,
    // usb transmit engine short packet handshake
    input  wire logic                                SHORT_PKT_REQ_IN,
    output logic                                     SHORT_PKT_GO_OUT
);
    import fifo_level_pkg::*;

    // ------------------------------------------------------------------
    // state and types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              arready;
        logic              bvalid;
        logic              rvalid;
        logic              have_aw;
        logic              have_w;
        logic [AXI_AW-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic [1:0]        bresp;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [DLY_W-1:0]  dly;
    } reg_state_type;

    localparam reg_state_type ST_RESET = '{
        awready: 1'b1,
        wready:  1'b1,
        arready: 1'b1,
        bvalid:  1'b0,
        rvalid:  1'b0,
        have_aw: 1'b0,
        have_w:  1'b0,
        waddr:   '0,
        wdata:   '0,
        wstrb:   '0,
        bresp:   RESP_OKAY,
        rresp:   RESP_OKAY,
        rdata:   '0,
        dly:     DLY_RESET
    };

    reg_state_type       st_q;
    reg_state_type       st_d;
    logic                aw_fire;
    logic                w_fire;
    logic                ar_fire;
    reg_sel_type         wsel;
    reg_sel_type         rsel;
    logic [31:0]         rd_word;
    logic [RX_LVL_W-1:0] rx_rd_lvl;
    logic [RX_LVL_W-1:0] rx_wr_lvl;
    logic [RX_PTR_W-1:0] rx_rd_ptr;
    logic [RX_PTR_W-1:0] rx_wr_ptr;
    logic [TX_LVL_W-1:0] tx_rd_lvl;
    logic [TX_LVL_W-1:0] tx_wr_lvl;
    logic [RX_PTR_W-1:0] rx_rd_sum;
    logic [RX_PTR_W-1:0] rx_wr_diff;

    // word decode, low two address bits ignored
    function automatic reg_sel_type reg_sel(input logic [AXI_AW-1:0] a);
        if (a[AXI_AW-1:2] == BULK_DLY_OFS[AXI_AW-1:2]) begin
            return SEL_DLY;
        end else if (a[AXI_AW-1:2] == RX_LVL_OFS[AXI_AW-1:2]) begin
            return SEL_RX_LVL;
        end else if (a[AXI_AW-1:2] == RX_PTR_OFS[AXI_AW-1:2]) begin
            return SEL_RX_PTR;
        end else if (a[AXI_AW-1:2] == TX_LVL_OFS[AXI_AW-1:2]) begin
            return SEL_TX_LVL;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // ------------------------------------------------------------------
    // FIFO trackers and delay timer
    // ------------------------------------------------------------------
    fifo_level_counter #(
        .LVL_W (RX_LVL_W),
        .PTR_W (RX_PTR_W)
    ) u_rx_track (
        .clk_in       (CLK_IN),
        .rstn_in      (RSTN_IN),
        .ce_in        (CE_IN),
        .wr_dword_in  (RX_WR_DWORD_IN),
        .wr_end_in    (RX_WR_END_IN),
        .wr_rewind_in (RX_WR_REWIND_IN),
        .rd_dword_in  (RX_RD_DWORD_IN),
        .rd_end_in    (RX_RD_END_IN),
        .rd_rewind_in (RX_RD_REWIND_IN),
        .rd_level_out (rx_rd_lvl),
        .wr_level_out (rx_wr_lvl),
        .rd_ptr_out   (rx_rd_ptr),
        .wr_ptr_out   (rx_wr_ptr)
    );

    // transmit read side is never rewound: data sent to the mac is gone
    fifo_level_counter #(
        .LVL_W (TX_LVL_W),
        .PTR_W (TX_PTR_W)
    ) u_tx_track (
        .clk_in       (CLK_IN),
        .rstn_in      (RSTN_IN),
        .ce_in        (CE_IN),
        .wr_dword_in  (TX_WR_DWORD_IN),
        .wr_end_in    (TX_WR_END_IN),
        .wr_rewind_in (TX_WR_REWIND_IN),
        .rd_dword_in  (TX_RD_DWORD_IN),
        .rd_end_in    (TX_RD_END_IN),
        .rd_rewind_in (1'b0),                                     // [R6]
        .rd_level_out (tx_rd_lvl),
        .wr_level_out (tx_wr_lvl),
        .rd_ptr_out   (),
        .wr_ptr_out   ()
    );

    bulk_in_delay_timer u_bulk_dly (
        .clk_in   (CLK_IN),
        .rstn_in  (RSTN_IN),
        .ce_in    (CE_IN),
        .delay_in (st_q.dly),                                     // [R1]
        .req_in   (SHORT_PKT_REQ_IN),
        .go_out   (SHORT_PKT_GO_OUT)
    );

    // ------------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------------

    // read word assembled from live levels; reserved bits stay zero
    always_comb begin
        rsel    = reg_sel(S_AXI_ARADDR_IN);
        rd_word = '0;
        if (rsel == SEL_DLY) begin
            rd_word[DLY_W-1:0] = st_q.dly;                        // [R2]
        end else if (rsel == SEL_RX_LVL) begin
            rd_word[RD_FLD_LSB +: RX_LVL_W] = rx_rd_lvl;          // [R11]
            rd_word[WR_FLD_LSB +: RX_LVL_W] = rx_wr_lvl;
        end else if (rsel == SEL_RX_PTR) begin
            rd_word[RD_FLD_LSB +: RX_PTR_W] = rx_rd_ptr;          // [R13]
            rd_word[WR_FLD_LSB +: RX_PTR_W] = rx_wr_ptr;
        end else if (rsel == SEL_TX_LVL) begin
            rd_word[RD_FLD_LSB +: TX_LVL_W] = tx_rd_lvl;          // [R12]
            rd_word[WR_FLD_LSB +: TX_LVL_W] = tx_wr_lvl;
        end
    end

    // address and data are taken independently; the write lands once
    // both are held, so one write is in flight at a time
    always_comb begin
        st_d    = st_q;
        aw_fire = S_AXI_AWVALID_IN && st_q.awready;
        w_fire  = S_AXI_WVALID_IN && st_q.wready;
        ar_fire = S_AXI_ARVALID_IN && st_q.arready;
        wsel    = reg_sel(st_q.waddr);
        if (aw_fire) begin
            st_d.have_aw = 1'b1;
            st_d.awready = 1'b0;
            st_d.waddr   = S_AXI_AWADDR_IN;
        end
        if (w_fire) begin
            st_d.have_w = 1'b1;
            st_d.wready = 1'b0;
            st_d.wdata  = S_AXI_WDATA_IN;
            st_d.wstrb  = S_AXI_WSTRB_IN;
        end
        if (st_q.have_aw && st_q.have_w && !st_q.bvalid) begin
            st_d.have_aw = 1'b0;
            st_d.have_w  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wsel == SEL_DLY) begin
                for (int b = 0; b < DLY_W / 8; b++) begin
                    if (st_q.wstrb[b]) begin
                        st_d.dly[8*b +: 8] = st_q.wdata[8*b +: 8]; // [R2]
                    end
                end
            end
        end
        if (st_q.bvalid && S_AXI_BREADY_IN) begin
            st_d.bvalid  = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end
        // read data is a snapshot taken at the address handshake
        if (ar_fire) begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rdata   = rd_word;
            st_d.rresp   = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (st_q.rvalid && S_AXI_RREADY_IN) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st_q <= ST_RESET;
        end else if (CE_IN) begin
            st_q <= st_d;
        end
    end

    assign S_AXI_AWREADY_OUT = st_q.awready;
    assign S_AXI_WREADY_OUT  = st_q.wready;
    assign S_AXI_BVALID_OUT  = st_q.bvalid;
    assign S_AXI_BRESP_OUT   = st_q.bresp;
    assign S_AXI_ARREADY_OUT = st_q.arready;
    assign S_AXI_RVALID_OUT  = st_q.rvalid;
    assign S_AXI_RDATA_OUT   = st_q.rdata;
    assign S_AXI_RRESP_OUT   = st_q.rresp;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------

    // level plus pointer on the read side moves only with a commit;
    // level minus pointer on the write side moves only with a drain
    assign rx_rd_sum  = RX_PTR_W'(rx_rd_lvl) + rx_rd_ptr;
    assign rx_wr_diff = RX_PTR_W'(rx_wr_lvl) - rx_wr_ptr;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    rx_commit_wait_a: assert property (                           // [R3]
        CE_IN && !RX_WR_END_IN && !RX_RD_DWORD_IN && !RX_RD_REWIND_IN
        |=> rx_rd_lvl == $past(rx_rd_lvl))
        else $error("rx read level moved without commit or read");

    rx_read_dec_a: assert property (                              // [R4]
        CE_IN && RX_RD_DWORD_IN && !RX_RD_REWIND_IN && !RX_WR_END_IN
        |=> rx_rd_lvl == $past(rx_rd_lvl) - 14'h0001)
        else $error("rx read level not lowered by one");

    tx_read_dec_a: assert property (                              // [R6]
        CE_IN && TX_RD_DWORD_IN && !TX_WR_END_IN
        |=> tx_rd_lvl == $past(tx_rd_lvl) - 12'h001)
        else $error("tx read level not lowered by one");

    rx_rewind_sum_a: assert property (                            // [R5]
        CE_IN && !RX_WR_END_IN |=> rx_rd_sum == $past(rx_rd_sum))
        else $error("rx read rewind lost words");

    rx_write_inc_a: assert property (                             // [R7]
        CE_IN && RX_WR_DWORD_IN && !RX_WR_REWIND_IN && !RX_RD_END_IN
        |=> rx_wr_lvl == $past(rx_wr_lvl) + 14'h0001)
        else $error("rx write level not raised by one");

    rx_wr_rewind_a: assert property (                             // [R9]
        CE_IN && !RX_RD_END_IN |=> rx_wr_diff == $past(rx_wr_diff))
        else $error("rx write rewind disagrees with pointer");

    tx_drain_wait_a: assert property (                            // [R8]
        CE_IN && !TX_WR_DWORD_IN && !TX_RD_END_IN && !TX_WR_REWIND_IN
        |=> $stable(tx_wr_lvl))
        else $error("tx write level moved without cause");

    zero_delay_go_a: assert property (                            // [R14]
        CE_IN && SHORT_PKT_REQ_IN && st_q.dly == 16'h0000
        |=> SHORT_PKT_GO_OUT)
        else $error("zero delay did not release at once");

    early_release_a: assert property (                            // [R1]
        (CE_IN && SHORT_PKT_REQ_IN && st_q.dly != 16'h0000)
        ##1 (!SHORT_PKT_REQ_IN)[*4] |-> !SHORT_PKT_GO_OUT)
        else $error("short packet released before one step");

    write_answer_a: assert property (                             // [R2]
        CE_IN && st_q.have_aw && st_q.have_w && !st_q.bvalid
        |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT)
        else $error("write response missing");

endmodule

/* verification/fifo_traffic_model.sv */
// far-side model: mac and usb engines pulsing word, end and rewind events
module fifo_traffic_model (
    input  wire logic        clk_in,
    output logic      [10:0] ev_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // events are single-cycle strobes, so the idle level is simply all low
    initial ev_out = '0;

    // n words on bit wb, then the closing strobe alone; a negative fin gives an idle cycle
    // the strobe never shares a cycle with a word, so no word is lost to a rewind
    task automatic pkt(input int wb, input int n, input int fin);
        for (int i = 0; i < n; i++) begin
            ev_out <= 11'h001 << wb;
            @(posedge clk_in);
        end
        ev_out <= (fin < 0) ? 11'h000 : 11'h001 << fin;
        @(posedge clk_in);
        ev_out <= '0;
        @(posedge clk_in);
    endtask
endmodule

/* verification/testbench.sv */
// self-checking bench for the packet fifo level tracker
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fifo_level_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, req = 1'b0, ce = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0]  awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic [3:0]  ws = '0;
    logic [1:0]  bresp, rresp;
    logic        awr, wr, bv, arr, rv, go;
    logic [10:0] ev;
    int          fails = 0, n_checks = 0;

    // 250 MHz core clock
    always #2 clk = ~clk;

    fifo_traffic_model i_src (.clk_in(clk), .ev_out(ev));
    packet_fifo_level_tracker i_dut (
        .CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
        .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
        .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
        .RX_WR_DWORD_IN(ev[0]), .RX_WR_END_IN(ev[1]), .RX_WR_REWIND_IN(ev[2]),
        .RX_RD_DWORD_IN(ev[3]), .RX_RD_END_IN(ev[4]), .RX_RD_REWIND_IN(ev[5]),
        .TX_WR_DWORD_IN(ev[6]), .TX_WR_END_IN(ev[7]), .TX_WR_REWIND_IN(ev[8]),
        .TX_RD_DWORD_IN(ev[9]), .TX_RD_END_IN(ev[10]),
        .SHORT_PKT_REQ_IN(req), .SHORT_PKT_GO_OUT(go)
    );

    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // axi4-lite write; ready signals stay high afterwards, which avoids a double drive
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_p && awr === 1'b1) begin
                aw_p = 1'b0;
                awv <= 1'b0;
            end
            if (w_p && wr === 1'b1) begin
                w_p = 1'b0;
                wv <= 1'b0;
            end
        end while (bv !== 1'b1);
        chk("bresp", er, bresp);
    endtask

    // axi4-lite read, data and response taken at the handshake edge
    task automatic axi_rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er = RESP_OKAY);
        logic ar_p;
        ar_p = 1'b1;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_p && arr === 1'b1) begin
                ar_p = 1'b0;
                arv <= 1'b0;
            end
        end while (rv !== 1'b1);
        chk(nm, e, rd);
        chk("rresp", er, rresp);
    endtask

    // cycles from the last request to the release pulse; k earlier requests test the reload
    task automatic tmr(input logic [15:0] n, input int k, input int lo, input int hi);
        int c;
        axi_wr(BULK_DLY_OFS, {16'h0000, n}, 4'hF, RESP_OKAY);
        repeat (k) begin
            req <= 1'b1;
            @(posedge clk);
            req <= 1'b0;
            repeat (9) @(posedge clk);
        end
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        c = 0;
        while (go !== 1'b1) begin
            @(posedge clk);
            c++;
        end
        chk("go_delay", 1, c >= lo && c <= hi);
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // reset, registers, fifo traffic, then the short packet timer
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        axi_rd("delay", BULK_DLY_OFS, {16'h0000, DLY_RESET});
        axi_rd("rx_lvl", RX_LVL_OFS, 0);
        axi_rd("rx_ptr", RX_PTR_OFS, 0);
        axi_rd("tx_lvl", TX_LVL_OFS, 0);
        axi_wr(BULK_DLY_OFS, 32'hFFFF_A5C3, 4'hF, RESP_OKAY);
        axi_wr(BULK_DLY_OFS, 32'h0000_7777, 4'h2, RESP_OKAY);
        axi_rd("delay", BULK_DLY_OFS, 32'h0000_77C3);
        axi_wr(RX_LVL_OFS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        axi_wr(8'h40, 32'h0000_0001, 4'hF, RESP_SLVERR);
        axi_rd("unmapped", 8'h40, 0, RESP_SLVERR);
        i_src.pkt(0, 3, -1);
        axi_rd("rx_lvl", RX_LVL_OFS, 32'h0000_0003);
        i_src.pkt(0, 0, 1);
        axi_rd("rx_lvl", RX_LVL_OFS, 32'h0003_0003);
        i_src.pkt(3, 2, -1);
        axi_rd("rx_ptr", RX_PTR_OFS, 32'h0002_0003);
        axi_rd("rx_lvl", RX_LVL_OFS, 32'h0001_0003);
        i_src.pkt(3, 0, 5);
        axi_rd("rx_lvl", RX_LVL_OFS, 32'h0003_0003);
        i_src.pkt(3, 3, -1);
        axi_rd("rx_lvl", RX_LVL_OFS, 32'h0000_0003);
        i_src.pkt(3, 0, 4);
        axi_rd("rx_lvl", RX_LVL_OFS, 0);
        i_src.pkt(0, 2, 2);
        axi_rd("rx_ptr", RX_PTR_OFS, 32'h0003_0003);
        axi_rd("rx_lvl", RX_LVL_OFS, 0);
        i_src.pkt(6, 2, 8);
        axi_rd("tx_lvl", TX_LVL_OFS, 0);
        i_src.pkt(6, 2, 7);
        axi_rd("tx_lvl", TX_LVL_OFS, 32'h0002_0002);
        i_src.pkt(9, 1, 5);
        axi_rd("tx_lvl", TX_LVL_OFS, 32'h0001_0002);
        i_src.pkt(9, 1, 10);
        axi_rd("tx_lvl", TX_LVL_OFS, 0);
        // events offered while the clock enable is low must leave the receive levels untouched
        ce <= 1'b0;
        i_src.pkt(0, 2, 1);
        ce <= 1'b1;
        axi_rd("rx_lvl_frozen", RX_LVL_OFS, 0);
        tmr(16'h0000, 0, 1, 1);
        tmr(16'h0006, 0, 24, 29);
        tmr(16'h0006, 1, 24, 29);
        conclude();
    end

    // cut a hang short; the sequence needs only a few hundred cycles
    initial begin
        #20us;
        fails++;
        conclude();
    end
endmodule
